// ==== shared/spim_pkg.sv ====
// constants, field layouts and types of the master spi block
// assumes an 8-bit register port with a 3-bit word address
package spim_pkg;

   // ************************************************************
   // register map (word addresses on the register port)
   // ************************************************************
   localparam logic [2:0] ADDR_DATA    = 3'h0;
   localparam logic [2:0] ADDR_FLAGS   = 3'h1;
   localparam logic [2:0] ADDR_ENABLES = 3'h2;
   localparam logic [2:0] ADDR_FORMAT  = 3'h3;
   localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
   localparam logic [2:0] ADDR_BAUD_HI = 3'h5;

   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int FLAG_RXC_BIT  = 7;
   localparam int FLAG_TXC_BIT  = 6;
   localparam int FLAG_UDRE_BIT = 5;
   localparam int BAUD_W        = 12;
   localparam int BAUD_HI_W     = 4;

   localparam logic [7:0]        ENABLES_RST = 8'h00;
   localparam logic [7:0]        FORMAT_RST  = 8'h00;
   localparam logic [BAUD_W-1:0] BAUD_RST    = 12'h000;

   // mode select encodings
   localparam logic [1:0] MODE_ASYNC = 2'h0;
   localparam logic [1:0] MODE_SYNC  = 2'h1;
   localparam logic [1:0] MODE_RSVD  = 2'h2;
   localparam logic [1:0] MODE_MSPI  = 2'h3;

   // ************************************************************
   // frame timing: 8 bits, two clock edges per bit
   // ************************************************************
   localparam logic [3:0] LAST_EDGE = 4'hF;

   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic       rx_complete_irq_en;
      logic       tx_complete_irq_en;
      logic       tx_empty_irq_en;
      logic       receiver_enable;
      logic       transmitter_enable;
      logic [2:0] reserved;
   } enables_t;

   typedef struct packed {
      logic [1:0] usart_mode_select;
      logic [2:0] reserved;
      logic       bit_order_select;
      logic       clock_phase_select;
      logic       clock_polarity_select;
   } format_t;

   typedef enum logic {ST_IDLE, ST_SHIFT} shift_state_t;

endpackage

// ==== src/baud_tick.sv ====
// half-period tick generator for the transfer clock
// assumes divisor is stable while run is high
`timescale 1ns/1ps
module baud_tick (
   input  wire logic                       clk,      // system clock
   input  wire logic                       rst_n,    // synchronised reset
   input  wire logic                       run,      // count while a frame runs
   input  wire logic [spim_pkg::BAUD_W-1:0] divisor, // half period minus one
   output logic                            tick      // one-cycle pulse per half period
);
   logic [spim_pkg::BAUD_W-1:0] cnt_q;
   logic [spim_pkg::BAUD_W-1:0] cnt_d;

   always_comb begin
      tick  = run && (cnt_q == divisor);
      cnt_d = cnt_q;
      if (!run || tick) begin
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule // baud_tick

// ==== src/spim_master.sv ====
// master-only spi mode of a serial port: registers, transmit buffer,
// shift engine, two-level receive buffer and interrupt request lines
// assumes pins are synchronised here and the cpu global enable is a level
//
// How it works
// - tx_buffer_empty_flag reads one whenever the transmit buffer can take a byte.
// - after reset the transmit buffer is empty, so the flag reads one.
// - receive-complete request needs its enable, global enable and a set flag.
// - transmit-complete request needs its enable, global enable and a set flag.
// - buffer-empty request needs its enable, global enable and an empty buffer.
// - receiver enable claims the serial input pin and samples it.
// - clearing the receiver enable flushes all unread received bytes at once.
// - without the transmitter, data writes are ignored, so no new frame starts.
// - transmitter enable claims and drives the serial output pin.
// - a disabled transmitter finishes buffered and shifting data before stopping.
// - once really stopped the transmitter releases the serial output pin.
// - mode field 11 selects master spi; other codes leave the block idle.
// - bit order, phase and polarity take effect in the mode-select write itself.
// - bit order one sends the least significant bit first, else the most.
// - clock phase picks sampling on the leading or the trailing edge.
// - clock polarity sets the idle level; with phase gives four spi modes.
// - receive-complete flag shows unread data and clears when receiver disabled.
// - transmit-complete sets after a frame with nothing buffered; ack or write-one clears.
// - frame, overrun and parity error bits always read zero.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module spim_master (
   input  wire logic       clk,                // system clock, 100 MHz
   input  wire logic       resetn,             // asynchronous reset, active low
   input  wire logic [2:0] addr,               // register word address
   input  wire logic [7:0] wdata,              // register write data
   input  wire logic       wr,                 // write strobe
   input  wire logic       rd,                 // read strobe
   output logic      [7:0] rdata,              // read data, cycle after rd
   input  wire logic       global_irq_en,      // cpu global interrupt flag
   input  wire logic       tx_complete_ack,    // transmit-complete interrupt taken
   input  wire logic       serial_in_pin,      // serial data from slaves
   output logic            serial_out_pin,     // serial data to slaves
   output logic            serial_out_oe,      // serial output overrides port
   output logic            serial_in_claim,    // serial input overrides port
   output logic            transfer_clock_pin, // transfer clock
   output logic            transfer_clock_oe,  // transfer clock driven
   output logic            rx_complete_irq,    // receive-complete request
   output logic            tx_complete_irq,    // transmit-complete request
   output logic            tx_empty_irq        // data-register-empty request
);

   // ************************************************************
   // reset release
   // ************************************************************
   logic [1:0] rst_pipe_q;
   logic       rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_pipe_q <= 2'h0;
      end else begin
         rst_pipe_q <= {rst_pipe_q[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe_q[1];

   // ************************************************************
   // declarations
   // ************************************************************
   spim_pkg::enables_t         enables_q, enables_d;
   spim_pkg::format_t          format_q,  format_d;
   logic [spim_pkg::BAUD_W-1:0] baud_q,    baud_d;
   logic                       txc_q,     txc_d;
   logic [7:0]                 rdata_d;
   logic                       rx_irq_d,  tx_irq_d,  empty_irq_d;
   logic                       sout_oe_d, sin_claim_d, sck_oe_d;

   spim_pkg::shift_state_t     state_q,   state_d;
   logic [3:0]                 edge_q,    edge_d;
   logic [7:0]                 tx_sh_q,   tx_sh_d;
   logic [7:0]                 rx_sh_q,   rx_sh_d;
   logic                       sout_q,    sout_d;
   logic                       sck_q,     sck_d;
   logic [7:0]                 txbuf_q,   txbuf_d;
   logic                       txfull_q,  txfull_d;
   logic [7:0]                 rxb0_q,    rxb0_d;
   logic [7:0]                 rxb1_q,    rxb1_d;
   logic [1:0]                 rxcnt_q,   rxcnt_d;

   logic                       sin_s;
   logic                       tick;
   logic                       spi_mode;
   logic                       lsb_first;
   logic                       sample_edge;
   logic                       shift_edge;
   logic                       frame_end;
   logic                       rx_pop;
   logic                       rx_push;
   logic [7:0]                 rx_byte;

   // ************************************************************
   // pin synchroniser and bit timing
   // ************************************************************
   sync2 #(.WIDTH(1)) u_sin_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (serial_in_pin),
      .q     (sin_s)
   );

   baud_tick u_baud (
      .clk     (clk),
      .rst_n   (rst_n),
      .run     (state_q == spim_pkg::ST_SHIFT),
      .divisor (baud_q),
      .tick    (tick)
   );

   assign spi_mode  = (format_q.usart_mode_select == spim_pkg::MODE_MSPI);
   assign lsb_first = format_q.bit_order_select;
   // sampling edge choice: even edges lead, odd edges trail
   assign sample_edge = (edge_q[0] == format_q.clock_phase_select);
   // first leading edge and last trailing edge never move the output bit
   assign shift_edge  = !sample_edge && (edge_q != 4'h0) && (edge_q != spim_pkg::LAST_EDGE);
   assign frame_end   = (state_q == spim_pkg::ST_SHIFT) && tick && (edge_q == spim_pkg::LAST_EDGE);
   assign rx_pop      = rd && (addr == spim_pkg::ADDR_DATA) && (rxcnt_q != 2'h0);

   always_comb begin
      rx_byte = rx_sh_q;
      if (tick && sample_edge) begin
         rx_byte = lsb_first ? {sin_s, rx_sh_q[7:1]} : {rx_sh_q[6:0], sin_s};
      end
   end
   assign rx_push = frame_end && enables_q.receiver_enable;

   // ************************************************************
   // shift engine, transmit buffer and receive buffer
   // ************************************************************
   always_comb begin
      state_d  = state_q;
      edge_d   = edge_q;
      tx_sh_d  = tx_sh_q;
      rx_sh_d  = rx_sh_q;
      sout_d   = sout_q;
      sck_d    = sck_q;
      txbuf_d  = txbuf_q;
      txfull_d = txfull_q;
      rxb0_d   = rxb0_q;
      rxb1_d   = rxb1_q;
      rxcnt_d  = rxcnt_q;

      // data write starts transfer; only with transmitter on
      if (wr && (addr == spim_pkg::ADDR_DATA) && spi_mode && enables_q.transmitter_enable && !txfull_q) begin
         txbuf_d  = wdata;
         txfull_d = 1'b1;
      end

      unique case (state_q)
         spim_pkg::ST_IDLE: begin
            sck_d = format_q.clock_polarity_select;
            // buffered byte still goes out after disable
            if (spi_mode && txfull_q) begin
               tx_sh_d  = txbuf_q;
               txfull_d = 1'b0;
               edge_d   = 4'h0;
               sout_d   = lsb_first ? txbuf_q[0] : txbuf_q[7];
               state_d  = spim_pkg::ST_SHIFT;
            end
         end
         spim_pkg::ST_SHIFT: begin
            if (tick) begin
               sck_d   = !sck_q;
               edge_d  = edge_q + 4'h1;
               rx_sh_d = rx_byte;
               if (shift_edge) begin
                  tx_sh_d = lsb_first ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
                  sout_d  = lsb_first ? tx_sh_q[1] : tx_sh_q[6];
               end
               if (edge_q == spim_pkg::LAST_EDGE) begin
                  state_d = spim_pkg::ST_IDLE;
               end
            end
         end
      endcase

      // pop before push; when full the newest byte is the one lost
      if (rx_pop) begin
         rxb0_d  = rxb1_q;
         rxcnt_d = rxcnt_q - 2'h1;
      end
      if (rx_push && (rxcnt_d != 2'h2)) begin
         if (rxcnt_d == 2'h0) begin
            rxb0_d = rx_byte;
         end else begin
            rxb1_d = rx_byte;
         end
         rxcnt_d = rxcnt_d + 2'h1;
      end
      if (!enables_q.receiver_enable) begin
         rxcnt_d = 2'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= spim_pkg::ST_IDLE;
         edge_q   <= 4'h0;
         tx_sh_q  <= 8'h00;
         rx_sh_q  <= 8'h00;
         sout_q   <= 1'b1;
         sck_q    <= 1'b0;
         txbuf_q  <= 8'h00;
         txfull_q <= 1'b0;
         rxb0_q   <= 8'h00;
         rxb1_q   <= 8'h00;
         rxcnt_q  <= 2'h0;
      end else begin
         state_q  <= state_d;
         edge_q   <= edge_d;
         tx_sh_q  <= tx_sh_d;
         rx_sh_q  <= rx_sh_d;
         sout_q   <= sout_d;
         sck_q    <= sck_d;
         txbuf_q  <= txbuf_d;
         txfull_q <= txfull_d;
         rxb0_q   <= rxb0_d;
         rxb1_q   <= rxb1_d;
         rxcnt_q  <= rxcnt_d;
      end
   end

   // ************************************************************
   // registers, flags, pin control and requests
   // ************************************************************
   always_comb begin
      enables_q_hold: begin
         enables_d = enables_q;
         format_d  = format_q;
         baud_d    = baud_q;
         txc_d     = txc_q;
         rdata_d   = 8'h00;
      end

      if (wr) begin
         unique case (addr)
            spim_pkg::ADDR_ENABLES: enables_d = spim_pkg::enables_t'({wdata[7:3], 3'h0});
            // all format fields in one write
            spim_pkg::ADDR_FORMAT:  format_d  = spim_pkg::format_t'({wdata[7:6], 3'h0, wdata[2:0]});
            spim_pkg::ADDR_BAUD_LO: baud_d[7:0] = wdata;
            spim_pkg::ADDR_BAUD_HI: baud_d[spim_pkg::BAUD_W-1:8] = wdata[spim_pkg::BAUD_HI_W-1:0];
            default: ;
         endcase
      end

      // clear by write-one or ack; a same-cycle set wins
      if ((wr && (addr == spim_pkg::ADDR_FLAGS) && wdata[spim_pkg::FLAG_TXC_BIT]) || tx_complete_ack) begin
         txc_d = 1'b0;
      end
      if (frame_end && !txfull_q) begin
         txc_d = 1'b1;
      end

      if (rd) begin
         unique case (addr)
            spim_pkg::ADDR_DATA:    rdata_d = rxb0_q;
            spim_pkg::ADDR_FLAGS:   rdata_d = {rxcnt_q != 2'h0, txc_q, !txfull_q, 5'h00};
            spim_pkg::ADDR_ENABLES: rdata_d = enables_q;
            spim_pkg::ADDR_FORMAT:  rdata_d = format_q;
            spim_pkg::ADDR_BAUD_LO: rdata_d = baud_q[7:0];
            spim_pkg::ADDR_BAUD_HI: rdata_d = {4'h0, baud_q[spim_pkg::BAUD_W-1:8]};
            default:                rdata_d = 8'h00;
         endcase
      end

      rx_irq_d    = enables_q.rx_complete_irq_en && global_irq_en && (rxcnt_q != 2'h0);
      tx_irq_d    = enables_q.tx_complete_irq_en && global_irq_en && txc_q;
      empty_irq_d = enables_q.tx_empty_irq_en && global_irq_en && !txfull_q;

      // output claimed until transmitter really idle
      sout_oe_d   = spi_mode && (enables_q.transmitter_enable || txfull_q || (state_q == spim_pkg::ST_SHIFT));
      sin_claim_d = spi_mode && enables_q.receiver_enable;
      sck_oe_d    = spi_mode;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enables_q          <= spim_pkg::enables_t'(spim_pkg::ENABLES_RST);
         format_q           <= spim_pkg::format_t'(spim_pkg::FORMAT_RST);
         baud_q             <= spim_pkg::BAUD_RST;
         txc_q              <= 1'b0;
         rdata              <= 8'h00;
         rx_complete_irq    <= 1'b0;
         tx_complete_irq    <= 1'b0;
         tx_empty_irq       <= 1'b0;
         serial_out_oe      <= 1'b0;
         serial_in_claim    <= 1'b0;
         transfer_clock_oe  <= 1'b0;
         serial_out_pin     <= 1'b1;
         transfer_clock_pin <= 1'b0;
      end else begin
         enables_q          <= enables_d;
         format_q           <= format_d;
         baud_q             <= baud_d;
         txc_q              <= txc_d;
         rdata              <= rdata_d;
         rx_complete_irq    <= rx_irq_d;
         tx_complete_irq    <= tx_irq_d;
         tx_empty_irq       <= empty_irq_d;
         serial_out_oe      <= sout_oe_d;
         serial_in_claim    <= sin_claim_d;
         transfer_clock_oe  <= sck_oe_d;
         serial_out_pin     <= sout_q;
         transfer_clock_pin <= sck_q;
      end
   end

endmodule // spim_master

// ==== src/sync2.sv ====
// two flip-flop synchroniser for levels from outside the clock domain
// assumes rst_n is already synchronous to clk
`timescale 1ns/1ps
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,    // system clock
   input  wire logic             rst_n,  // synchronised reset
   input  wire logic [WIDTH-1:0] d,      // asynchronous input
   output logic      [WIDTH-1:0] q       // synchronised output
);
   logic [WIDTH-1:0] meta_q;

   // first stage is read only by the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // sync2

// ==== verif/spi_slave_model.sv ====
// behavioural spi slave that echoes the previous byte it took
// assumes no select line: rst realigns it to a frame boundary
`timescale 1ns/1ps
module spi_slave_model #(
   parameter logic [7:0] FIRST = 8'h3C // first reply, value arbitrary
) (
   input  wire logic       rst,  // realign to a frame
   input  wire logic       sclk, // transfer clock
   input  wire logic       mosi, // data from master
   input  wire logic       cpha, // clock phase
   input  wire logic       lsb,  // bit order
   output logic            miso, // data to master
   output logic      [7:0] got   // last whole byte taken
);
   logic [4:0] e   = 5'h00;
   logic [7:0] sh  = 8'h00;
   logic [7:0] rep = FIRST;
   int         k;
   initial miso = 1'b1;
   initial got = 8'h00;
   always @(posedge sclk or negedge sclk or posedge rst) begin
      if (rst) begin
         e = 5'h00;
      end else begin
         k = lsb ? int'(e[3:1]) : 7 - int'(e[3:1]);
         // sample on leading edge in phase 0, trailing in phase 1
         if (e[0] == cpha) sh[k] = mosi;
         e = e + 5'h01;
         if (e == 5'h10) begin
            got = sh;
            rep = sh;
            e = 5'h00;
         end
      end
      // reply in the selected bit order
      k = lsb ? int'(e[3:1]) : 7 - int'(e[3:1]);
      // hold time over after a trailing edge in phase 1: no stale level
      if (cpha && !e[0]) miso = ~miso;
      else miso = rep[k];
   end
endmodule // spi_slave_model

// ==== verif/spim_master_checker.sv ====
// concurrent checks on the ports of the master spi block
// assumes one clock domain; bound to every spim_master instance
`timescale 1ns/1ps
module spim_master_checker (
   input wire logic       clk,                // system clock
   input wire logic       resetn,             // reset, active low
   input wire logic [2:0] addr,               // word address
   input wire logic       rd,                 // read strobe
   input wire logic [7:0] rdata,              // read data
   input wire logic       global_irq_en,      // global enable
   input wire logic       tx_complete_ack,    // request taken
   input wire logic       serial_out_oe,      // data pin owned
   input wire logic       transfer_clock_pin, // transfer clock
   input wire logic       transfer_clock_oe,  // clock pin owned
   input wire logic       rx_complete_irq,    // rx request
   input wire logic       tx_complete_irq,    // tx request
   input wire logic       tx_empty_irq        // empty request
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_rx_irq_gate: assert property (rx_complete_irq |-> $past(global_irq_en))
      else $error("rx request without global enable");
   a_tx_irq_gate: assert property (tx_complete_irq |-> $past(global_irq_en))
      else $error("tx request without global enable");
   a_empty_irq_off: assert property (!global_irq_en [*2] |-> !tx_empty_irq)
      else $error("empty request while globally masked");
   a_ack_clears_irq: assert property (tx_complete_ack |-> ##2 !tx_complete_irq)
      else $error("tx request survives acknowledge");
   a_flag_rsvd_zero: assert property ($past(rd) && $past(addr) == spim_pkg::ADDR_FLAGS |-> rdata[4:0] == 5'h00)
      else $error("unused flag bits read nonzero");
   a_out_needs_mode: assert property (serial_out_oe |-> transfer_clock_oe)
      else $error("data pin driven outside spi mode");
   a_no_clk_rx_only: assert property ($changed(transfer_clock_pin) && transfer_clock_oe && $past(transfer_clock_oe)
      |-> serial_out_oe || $past(serial_out_oe))
      else $error("clock moves without transmitter");
   // baud is kept at three or more, so a half period spans four or more cycles
   a_half_period_min: assert property ($changed(transfer_clock_pin) |=> $stable(transfer_clock_pin) [*3])
      else $error("transfer clock half period too short");

   c_rx_irq: cover property (rx_complete_irq);
   c_tx_off: cover property ($fell(serial_out_oe));
   c_ack: cover property (tx_complete_ack ##2 !tx_complete_irq);
endmodule // spim_master_checker

bind spim_master spim_master_checker chk_i (.clk, .resetn, .addr, .rd, .rdata, .global_irq_en, .tx_complete_ack,
   .serial_out_oe, .transfer_clock_pin, .transfer_clock_oe, .rx_complete_irq, .tx_complete_irq, .tx_empty_irq);

// ==== verif/usart_master_spi_mode_tb.sv ====
// self-checking bench for the master spi block
// assumes the package, design, checker and slave model are compiled first
`timescale 1ns/1ps
module usart_master_spi_mode_tb;
   localparam logic [7:0] FIRST_REPLY = 8'h3C; // arbitrary
   logic       clk    = 1'b0;
   logic       resetn = 1'b0;
   logic [2:0] addr   = 3'h0;
   logic [7:0] wdata  = 8'h00;
   logic       wr     = 1'b0;
   logic       rd     = 1'b0;
   logic       gie    = 1'b0;
   logic       ack    = 1'b0;
   logic       srst   = 1'b0;
   logic       cpha   = 1'b0;
   logic       lsb    = 1'b0;
   logic [7:0] prev   = FIRST_REPLY;
   logic [7:0] rdata, got, rv, b, en;
   logic       miso, mosi, mo_oe, claim, sclk, sclk_oe, irq_rx, irq_tx, irq_em;
   int         bad_count = 0;
   int         compares  = 0;
   int         seed      = 32'hed7d;
   int         edges     = 0;
   int         m;

   spim_master DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .global_irq_en(gie), .tx_complete_ack(ack), .serial_in_pin(miso), .serial_out_pin(mosi),
      .serial_out_oe(mo_oe), .serial_in_claim(claim), .transfer_clock_pin(sclk), .transfer_clock_oe(sclk_oe),
      .rx_complete_irq(irq_rx), .tx_complete_irq(irq_tx), .tx_empty_irq(irq_em));
   spi_slave_model #(.FIRST(FIRST_REPLY)) slave (.rst(srst), .sclk(sclk), .mosi(mosi), .cpha(cpha), .lsb(lsb),
      .miso(miso), .got(got));

   always #5 clk = ~clk;
   always @(sclk) edges++;

   // ************************************************************
   // tasks and expectations
   // ************************************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [2:0] a, output logic [7:0] v);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      // data stand only until this edge: take them before it updates
      @(posedge clk);
      v = rdata;
   endtask
   task automatic waitf(input int n);
      int i;
      i = 0;
      rv = 8'h00;
      while (rv[n] !== 1'b1 && i < 200) begin
         rreg(spim_pkg::ADDR_FLAGS, rv);
         i++;
      end
      chk(8'(rv[n]), 8'h01);
   endtask
   task automatic setfmt(input logic [7:0] f);
      wreg(spim_pkg::ADDR_FORMAT, f);
      cpha <= f[1];
      lsb <= f[2];
      repeat (3) @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
   endtask
   // mode and frame format in one write, reserved bits zero
   function automatic logic [7:0] fmt_byte(input int i);
      return {spim_pkg::MODE_MSPI, 3'b000, 3'(i)};
   endfunction
   function automatic logic [7:0] exp_irq(input logic [7:0] e, input logic g);
      return 8'(e[7:5] & {3{g}});
   endfunction
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // sequence
   // ************************************************************
   initial begin
      #400000;
      bad_count++;
      close_out();
   end
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rreg(spim_pkg::ADDR_FLAGS, rv);
      chk(rv, 8'h20);
      wreg(3'h7, 8'hFF);
      for (m = 2; m < 8; m++) begin
         rreg(3'(m), rv);
         chk(rv, 8'h00);
      end
      for (m = 0; m < 16; m++) begin
         // two input flops plus the pin register need baud of three or more
         b = 8'($unsigned($random(seed)) % 4 + 3);
         wreg(spim_pkg::ADDR_BAUD_LO, b);
         rreg(spim_pkg::ADDR_BAUD_LO, rv);
         chk(rv, b);
         setfmt(fmt_byte(m));
         chk(8'(sclk), 8'(m[0]));
         en = {3'($random(seed)), 5'h18};
         gie <= 1'($random(seed));
         wreg(spim_pkg::ADDR_ENABLES, en);
         rreg(spim_pkg::ADDR_ENABLES, rv);
         chk(rv, en);
         chk(8'({mo_oe, claim, sclk_oe}), 8'h07);
         b = 8'($random(seed));
         edges = 0;
         wreg(spim_pkg::ADDR_DATA, b);
         waitf(6);
         chk(8'(edges), 8'h10);
         chk(got, b);
         rreg(spim_pkg::ADDR_FLAGS, rv);
         chk(rv, 8'hE0);
         chk(8'({irq_rx, irq_tx, irq_em}), exp_irq(en, gie));
         if (m[3]) begin
            ack <= 1'b1;
            @(posedge clk);
            ack <= 1'b0;
         end else begin
            wreg(spim_pkg::ADDR_FLAGS, 8'h40);
         end
         rreg(spim_pkg::ADDR_FLAGS, rv);
         chk(rv, 8'hA0);
         rreg(spim_pkg::ADDR_DATA, rv);
         chk(rv, prev);
         prev = b;
         rreg(spim_pkg::ADDR_FLAGS, rv);
         chk(rv, 8'h20);
      end
      // three back-to-back frames left unread: the third byte is lost
      edges = 0;
      for (m = 1; m < 4; m++) begin
         wreg(spim_pkg::ADDR_DATA, 8'(m * 17));
         waitf(5);
      end
      waitf(6);
      chk(8'(edges), 8'h30);
      rreg(spim_pkg::ADDR_DATA, rv);
      chk(rv, prev);
      rreg(spim_pkg::ADDR_DATA, rv);
      chk(rv, 8'h11);
      rreg(spim_pkg::ADDR_FLAGS, rv);
      chk(rv, 8'h60);
      chk(got, 8'h33);
      wreg(spim_pkg::ADDR_FLAGS, 8'h40);
      edges = 0;
      wreg(spim_pkg::ADDR_DATA, 8'hA5);
      waitf(5);
      wreg(spim_pkg::ADDR_DATA, 8'h5A);
      wreg(spim_pkg::ADDR_ENABLES, 8'h10);
      chk(8'(mo_oe), 8'h01);
      waitf(6);
      repeat (3) @(posedge clk);
      chk(8'(edges), 8'h20);
      chk(8'(mo_oe), 8'h00);
      rreg(spim_pkg::ADDR_FLAGS, rv);
      chk(rv, 8'hE0);
      wreg(spim_pkg::ADDR_ENABLES, 8'h00);
      wreg(spim_pkg::ADDR_ENABLES, 8'h10);
      rreg(spim_pkg::ADDR_FLAGS, rv);
      chk(rv, 8'h60);
      chk(8'(claim), 8'h01);
      wreg(spim_pkg::ADDR_FLAGS, 8'h40);
      wreg(spim_pkg::ADDR_DATA, 8'hC3);
      edges = 0;
      repeat (100) @(posedge clk);
      chk(8'(edges), 8'h00);
      rreg(spim_pkg::ADDR_FLAGS, rv);
      chk(rv, 8'h20);
      wreg(spim_pkg::ADDR_ENABLES, 8'h18);
      for (m = 0; m < 3; m++) begin
         wreg(spim_pkg::ADDR_FORMAT, {2'(m), 6'h00});
         wreg(spim_pkg::ADDR_DATA, 8'h96);
         edges = 0;
         repeat (100) @(posedge clk);
         chk(8'(edges), 8'h00);
         chk(8'({sclk_oe, mo_oe}), 8'h00);
      end
      close_out();
   end
endmodule // usart_master_spi_mode_tb
